// [apocr_chk.sv]
// Checker: port assertions for the configuration register bank
`timescale 1ns/10ps
`default_nettype none

module apocr_chk (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic processing_bypass_i,
	input wire logic [7:0] reg_rdata_o,
	input wire apocr_pkg::apocr_proc_ctl_t proc_ctl_o,
	input wire apocr_pkg::apocr_out_ctl_t out_ctl_o
);
	// ********************************
	// Shadow of accepted writes
	// ********************************
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	localparam logic [31:0] SPD = 32'h555F_6A05;
	logic [7:0] p, o;
	logic upd, dem, hp, ho;
	logic [7:0] ep;
	logic [12:0] eo;
	assign hp = reg_addr_i == apocr_pkg::PROC_CFG_OFFSET;
	assign ho = reg_addr_i == apocr_pkg::OUT_CFG_OFFSET;
	assign dem = p[2] & ~processing_bypass_i;
	assign ep = {~p[0], p[0], p[1], p[1], dem, ~dem, p[3], p[4]};
	assign eo = {SPD[{p[7:5], 2'b00} +: 4], ~o[0], ~o[1], ~o[2], o[3], o[4],
		~o[4], o[5], o[6], o[7]};
	// Upd marks an enabled edge out of reset; frozen cycles are vacuous
	always_ff @(posedge ref_clk_i) begin
		upd <= clk_en_i & ~reset_i;
		if (reset_i) begin
			p <= 8'h00;
			o <= 8'h00;
		end else begin
			if (clk_en_i && reg_wr_i && hp) p <= reg_wdata_i;
			if (clk_en_i && reg_wr_i && ho) o <= reg_wdata_i;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	property p_hp; upd |-> proc_ctl_o[7:6] == $past(ep[7:6]); endproperty
	a_hp: assert property (p_hp) else $error("highpass decode");
	property p_lim; upd |-> proc_ctl_o[5:4] == $past(ep[5:4]); endproperty
	a_lim: assert property (p_lim) else $error("limiter mode");
	property p_dem; upd |-> proc_ctl_o[3:2] == $past(ep[3:2]); endproperty
	a_dem: assert property (p_dem) else $error("deemphasis");
	property p_link; upd |-> proc_ctl_o[1:0] == $past(ep[1:0]); endproperty
	a_link: assert property (p_link) else $error("link bits");
	property p_rate; upd |-> out_ctl_o[12:9] == $past(eo[12:9]); endproperty
	a_rate: assert property (p_rate) else $error("pwm rate");
	property p_off; upd |-> out_ctl_o[8:6] == $past(eo[8:6]); endproperty
	a_off: assert property (p_off) else $error("output stops");
	property p_am; upd |-> out_ctl_o[5:3] == $past(eo[5:3]); endproperty
	a_am: assert property (p_am) else $error("am modes");
	property p_sel; upd |-> out_ctl_o[2:0] == $past(eo[2:0]); endproperty
	a_sel: assert property (p_sel) else $error("coeff selects");
	property p_rd;
		clk_en_i && reg_rd_i && (hp || ho) |=>
			reg_rdata_o == $past(hp ? p : o);
	endproperty
	a_rd: assert property (p_rd) else $error("read data");
	property p_rdz;
		clk_en_i && !(reg_rd_i && (hp || ho)) |=> reg_rdata_o == 8'h00;
	endproperty
	a_rdz: assert property (p_rdz) else $error("idle read data");
	// A low enable must hold read data and every control output
	property p_frz;
		!clk_en_i |=> $stable(reg_rdata_o) && $stable(proc_ctl_o) &&
			$stable(out_ctl_o);
	endproperty
	a_frz: assert property (p_frz) else $error("frozen outputs");
endmodule : apocr_chk

bind apocr_output_config_regs apocr_chk i_apocr_chk (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.processing_bypass_i(processing_bypass_i), .reg_rdata_o(reg_rdata_o),
	.proc_ctl_o(proc_ctl_o), .out_ctl_o(out_ctl_o));
`default_nettype wire

// [apocr_output_config_regs.sv]
// Module: processing and output configuration registers with decoded controls
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module apocr_output_config_regs (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic processing_bypass_i,
	output logic [7:0] reg_rdata_o,
	output var apocr_pkg::apocr_proc_ctl_t proc_ctl_o,
	output var apocr_pkg::apocr_out_ctl_t out_ctl_o
);

	// ********************************
	// Bus decode
	// ********************************
	apocr_pkg::apocr_bus_t bus;
	logic [7:0] processing_config;
	logic [7:0] output_config;
	logic [7:0] rdata;
	apocr_pkg::apocr_proc_ctl_t proc_ctl;
	apocr_pkg::apocr_out_ctl_t out_ctl;

	assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
		wr: reg_wr_i, rd: reg_rd_i};

	wire hit_proc = bus.addr == apocr_pkg::PROC_CFG_OFFSET;
	wire hit_out = bus.addr == apocr_pkg::OUT_CFG_OFFSET;
	wire wr_proc = bus.wr & hit_proc;
	wire wr_out = bus.wr & hit_out;
	wire [7:0] next_rdata = hit_proc ? processing_config :
		hit_out ? output_config : apocr_pkg::UNMAPPED_READ;

	// ********************************
	// Storage
	// ********************************
	// Written bits hold until rewritten or reset
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			processing_config <= apocr_pkg::PROC_CFG_RESET;
			output_config <= apocr_pkg::OUT_CFG_RESET;
		end else if (clk_en_i) begin
			if (wr_proc) begin
				processing_config <= bus.wdata;
			end
			if (wr_out) begin
				output_config <= bus.wdata;
			end
		end
	end

	// Read data stands from the enabled edge of the strobe until the next enabled edge
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata <= apocr_pkg::UNMAPPED_READ;
		end else if (clk_en_i) begin
			rdata <= bus.rd ? next_rdata : apocr_pkg::UNMAPPED_READ;
		end
	end
	assign reg_rdata_o = rdata;

	// ********************************
	// Processing chain decode
	// ********************************
	wire hp_byp = processing_config[apocr_pkg::HIGHPASS_BYPASS_POS];
	wire lim_cmp = processing_config[apocr_pkg::LIMITER_COMPRESS_POS];
	wire deemph = processing_config[apocr_pkg::DEEMPHASIS_POS];
	wire [2:0] pwm_rate_sel = processing_config[apocr_pkg::PWM_RATE_LSB +: 3];
	// De-emphasis is dead while the processing bypass is on
	wire deemph_live = deemph & ~processing_bypass_i;

	assign proc_ctl.highpass_in_path = ~hp_byp;
	assign proc_ctl.biquad1_user = hp_byp;
	assign proc_ctl.limiter_compress_sel = lim_cmp;
	// Fixed thresholds when clear, volume-tracking when set
	assign proc_ctl.limiter_track_volume = lim_cmp;
	assign proc_ctl.deemphasis_active = deemph_live;
	assign proc_ctl.biquad7_user = ~deemph_live;
	assign proc_ctl.postscale_link =
		processing_config[apocr_pkg::POSTSCALE_LINK_POS];
	assign proc_ctl.coeff_link =
		processing_config[apocr_pkg::COEFF_LINK_POS];

	// ********************************
	// Output stage decode
	// ********************************
	apocr_pkg::apocr_speed_t speed_main;
	apocr_pkg::apocr_speed_t speed_hi;

	// Undefined codes fall back to normal speed rather than stop output
	always_comb begin
		speed_main = apocr_pkg::APOCR_SPEED_NORMAL;
		speed_hi = apocr_pkg::APOCR_SPEED_NORMAL;
		case (pwm_rate_sel)
			apocr_pkg::PWM_RATE_NORMAL: begin
				speed_main = apocr_pkg::APOCR_SPEED_NORMAL;
				speed_hi = apocr_pkg::APOCR_SPEED_NORMAL;
			end
			apocr_pkg::PWM_RATE_HALF: begin
				speed_main = apocr_pkg::APOCR_SPEED_HALF;
				speed_hi = apocr_pkg::APOCR_SPEED_HALF;
			end
			apocr_pkg::PWM_RATE_DOUBLE: begin
				speed_main = apocr_pkg::APOCR_SPEED_DOUBLE;
				speed_hi = apocr_pkg::APOCR_SPEED_DOUBLE;
			end
			apocr_pkg::PWM_RATE_MIXED: begin
				speed_main = apocr_pkg::APOCR_SPEED_NORMAL;
				speed_hi = apocr_pkg::APOCR_SPEED_DOUBLE;
			end
			apocr_pkg::PWM_RATE_ODD: begin
				speed_main = apocr_pkg::APOCR_SPEED_ODD;
				speed_hi = apocr_pkg::APOCR_SPEED_ODD;
			end
			default: begin
				speed_main = apocr_pkg::APOCR_SPEED_NORMAL;
				speed_hi = apocr_pkg::APOCR_SPEED_NORMAL;
			end
		endcase
	end

	wire am2 = output_config[apocr_pkg::AM_REDUCE2_POS];

	assign out_ctl.speed_ch1_6 = speed_main;
	assign out_ctl.speed_ch7_8 = speed_hi;
	assign out_ctl.pwm_run =
		~output_config[apocr_pkg::PWM_OUT_OFF_POS];
	assign out_ctl.serial_run =
		~output_config[apocr_pkg::SERIAL_OUT_OFF_POS];
	assign out_ctl.clock_run =
		~output_config[apocr_pkg::CLOCK_OUT_OFF_POS];
	assign out_ctl.am_noise_reduce_en =
		output_config[apocr_pkg::AM_REDUCE_POS];
	assign out_ctl.am_noise_reduce2_en = am2;
	assign out_ctl.noise_shaper_on = ~am2;
	assign out_ctl.headphone_en =
		output_config[apocr_pkg::HEADPHONE_POS];
	assign out_ctl.distortion_coeff_sel =
		output_config[apocr_pkg::DISTORTION_SEL_POS];
	assign out_ctl.maxpower_coeff_sel =
		output_config[apocr_pkg::MAXPOWER_SEL_POS];

	// ********************************
	// Registered control outputs
	// ********************************
	// One extra cycle of latency keeps every output on a flip-flop
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			proc_ctl_o <= '0;
			out_ctl_o <= '0;
		end else if (clk_en_i) begin
			proc_ctl_o <= proc_ctl;
			out_ctl_o <= out_ctl;
		end
	end

endmodule : apocr_output_config_regs

`default_nettype wire

// [apocr_pkg.sv]
// Package: offsets, reset values, field positions and carriers for the config bank
`default_nettype none

package apocr_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] PROC_CFG_OFFSET = 8'h05;
	localparam logic [7:0] OUT_CFG_OFFSET = 8'h06;
	localparam logic [7:0] PROC_CFG_RESET = 8'h00;
	localparam logic [7:0] OUT_CFG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ********************************
	// Field positions
	// ********************************
	localparam int HIGHPASS_BYPASS_POS = 0;
	localparam int LIMITER_COMPRESS_POS = 1;
	localparam int DEEMPHASIS_POS = 2;
	localparam int POSTSCALE_LINK_POS = 3;
	localparam int COEFF_LINK_POS = 4;
	localparam int PWM_RATE_LSB = 5;
	localparam int PWM_OUT_OFF_POS = 0;
	localparam int SERIAL_OUT_OFF_POS = 1;
	localparam int CLOCK_OUT_OFF_POS = 2;
	localparam int AM_REDUCE_POS = 3;
	localparam int AM_REDUCE2_POS = 4;
	localparam int HEADPHONE_POS = 5;
	localparam int DISTORTION_SEL_POS = 6;
	localparam int MAXPOWER_SEL_POS = 7;

	// ********************************
	// Output rate codes
	// ********************************
	localparam logic [2:0] PWM_RATE_NORMAL = 3'h0;
	localparam logic [2:0] PWM_RATE_HALF = 3'h1;
	localparam logic [2:0] PWM_RATE_DOUBLE = 3'h2;
	localparam logic [2:0] PWM_RATE_MIXED = 3'h3;
	localparam logic [2:0] PWM_RATE_ODD = 3'h4;

	typedef enum logic [1:0] {
		APOCR_SPEED_HALF,
		APOCR_SPEED_NORMAL,
		APOCR_SPEED_DOUBLE,
		APOCR_SPEED_ODD
	} apocr_speed_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} apocr_bus_t;

	typedef struct packed {
		logic highpass_in_path;
		logic biquad1_user;
		logic limiter_compress_sel;
		logic limiter_track_volume;
		logic deemphasis_active;
		logic biquad7_user;
		logic postscale_link;
		logic coeff_link;
	} apocr_proc_ctl_t;

	typedef struct packed {
		apocr_speed_t speed_ch1_6;
		apocr_speed_t speed_ch7_8;
		logic pwm_run;
		logic serial_run;
		logic clock_run;
		logic am_noise_reduce_en;
		logic am_noise_reduce2_en;
		logic noise_shaper_on;
		logic headphone_en;
		logic distortion_coeff_sel;
		logic maxpower_coeff_sel;
	} apocr_out_ctl_t;

endpackage : apocr_pkg

`default_nettype wire

// [tb_top.sv]
// Testbench: directed scenarios for the configuration register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// ********************************
	// Stimulus and checking
	// ********************************
	localparam logic [31:0] SPD = 32'h555F_6A05;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, byp = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rdata, cp, co;
	apocr_pkg::apocr_proc_ctl_t pc;
	apocr_pkg::apocr_out_ctl_t oc;
	int fail_count = 0, n_checks = 0;
	apocr_output_config_regs i_apocr_output_config_regs (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.processing_bypass_i(byp), .reg_rdata_o(rdata), .proc_ctl_o(pc),
		.out_ctl_o(oc));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	task automatic give_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	task automatic cmp(string n, logic [20:0] e, logic [20:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic wr(logic [7:0] a, logic [7:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 cmp("rdata", 21'(e), 21'(rdata));
		@(posedge ref_clk_i);
	endtask : rd
	// Expected decode is rebuilt here from the shadow values and the byp input
	task automatic ctl();
		logic x;
		x = cp[2] & ~byp;
		#1 cmp("controls", {~cp[0], cp[0], cp[1], cp[1], x, ~x, cp[3], cp[4],
			SPD[{cp[7:5], 2'b00} +: 4], ~co[0], ~co[1], ~co[2], co[3], co[4],
			~co[4], co[5], co[6], co[7]}, {pc, oc});
		@(posedge ref_clk_i);
	endtask : ctl
	task automatic t_proc();
		for (int i = 0; i < 8; i++) begin
			cp = {3'(i), i[0] ? 5'h15 : 5'h0A};
			wr(8'h05, cp);
			ctl();
			rd(8'h05, cp);
		end
	endtask : t_proc
	task automatic t_out();
		for (int i = 0; i < 8; i++) begin
			co = 8'h01 << i;
			wr(8'h06, co);
			ctl();
			rd(8'h06, co);
		end
	endtask : t_out
	task automatic t_byp();
		cp = 8'h04;
		wr(8'h05, cp);
		byp <= 1'b1;
		@(posedge ref_clk_i);
		ctl();
		byp <= 1'b0;
		@(posedge ref_clk_i);
		ctl();
	endtask : t_byp
	// Unmapped writes and writes while frozen must leave both registers alone
	// A read while frozen must not load read data either
	task automatic t_refuse();
		wr(8'h07, 8'hFF);
		clk_en_i <= 1'b0;
		wr(8'h06, 8'hFF);
		rd(8'h05, 8'h00);
		clk_en_i <= 1'b1;
		rd(8'h07, 8'h00);
		rd(8'h06, co);
		rd(8'h05, cp);
	endtask : t_refuse
	initial begin
		repeat (10) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		{cp, co} = 16'h0000;
		@(posedge ref_clk_i);
		rd(8'h05, 8'h00);
		ctl();
		t_proc();
		t_out();
		t_byp();
		t_refuse();
		reset_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		{cp, co} = 16'h0000;
		@(posedge ref_clk_i);
		rd(8'h06, 8'h00);
		ctl();
		give_verdict();
	end
	initial begin
		repeat (2000) @(posedge ref_clk_i);
		fail_count++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
